// ---- logic/cid_pkg.sv ----
// package: opcode classes, sub-codes, field positions and carriers of the decoder
package cid_pkg;

    typedef enum logic [5:0] {
        OP_NOP,
        OP_ADD,
        OP_SUM_WITH_CARRY,
        OP_SUB,
        OP_DIFFERENCE_WITH_BORROW,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_CMP,
        OP_MOV,
        OP_REGISTER_PRODUCT,
        OP_DIVIDE,
        OP_LONG_QUOTIENT,
        OP_ONES_COMPLEMENT,
        OP_TWOS_NEGATE,
        OP_BIT_CLEAR,
        OP_BIT_SET,
        OP_BIT_TRANSFER,
        OP_BIT_LOGIC,
        OP_BIT_COMPARE,
        OP_MASKED_FIELD_MODIFY,
        OP_COMPARE_THEN_DECREMENT,
        OP_COMPARE_THEN_INCREMENT,
        OP_NORMALISE_COUNT,
        OP_SHIFT_ROTATE,
        OP_SIGNED_RIGHT_SHIFT,
        OP_BYTE_WIDEN_SIGNED,
        OP_BYTE_WIDEN_ZERO,
        OP_BRANCH,
        OP_FAR_BRANCH,
        OP_BRANCH_BIT,
        OP_BRANCH_TEST_CLEAR,
        OP_BRANCH_TEST_SET,
        OP_CALL,
        OP_FAR_SUBROUTINE_CALL,
        OP_PUSH_THEN_CALL,
        OP_TRAP,
        OP_PUSH,
        OP_POP,
        OP_CONTEXT_SWITCH,
        OP_RETURN,
        OP_RETURN_WITH_POP,
        OP_SYSTEM,
        OP_WATCHDOG,
        OP_PREFIX,
        OP_PREFIX_LONG,
        OP_COPROC,
        OP_ILLEGAL
    } cid_op_t;

    typedef enum logic {
        ST_FIRST,
        ST_SECOND
    } cid_state_t;

    // field positions in the first instruction word
    localparam int OPC_LSB   = 10;
    localparam int SUB_LSB   = 8;
    localparam int REG_A_LSB = 4;
    localparam int REG_B_LSB = 0;
    // bit positions inside the sub-code
    localparam int SUB_LONG  = 1;
    localparam int SUB_BYTE  = 0;

    localparam logic [1:0] SYS_END_OF_INIT    = 2'h0;
    localparam logic [1:0] SYS_SOFTWARE_RESET = 2'h1;
    localparam logic [1:0] SYS_IDLE           = 2'h2;
    localparam logic [1:0] SYS_POWER_DOWN     = 2'h3;
    localparam logic [1:0] WDT_SERVICE        = 2'h0;
    localparam logic [1:0] WDT_DISABLE        = 2'h1;
    localparam logic [1:0] PFX_UNINTERRUPT    = 2'h0;
    localparam logic [1:0] PFX_REGISTER       = 2'h1;
    localparam logic [1:0] PFX_PAGE           = 2'h2;
    localparam logic [1:0] PFX_SEGMENT        = 2'h3;
    localparam logic [1:0] MAC_MAX_OPERANDS   = 2'h2;

    localparam logic [2:0]  PFX_LEFT_RST  = 3'h0;
    localparam logic [15:0] WORD_RST      = 16'h0000;
    localparam logic        NMI_RST_LEVEL = 1'b1;

    typedef struct packed {
        cid_op_t     op;
        logic [1:0]  sub;
        logic        len4;
        logic [3:0]  reg_a;
        logic [3:0]  reg_b;
        logic [15:0] ext;
        logic        prefixed;
        logic [1:0]  pfx_kind;
    } cid_issue_t;

    typedef struct packed {
        logic [1:0] count;
        logic [3:0] addr_a;
        logic [3:0] addr_b;
    } cid_mac_t;

    typedef struct packed {
        logic reset_output_pin;
        logic soft_reset;
        logic idle_mode;
        logic power_down_mode;
        logic wdt_service;
        logic wdt_disabled;
    } cid_sys_t;

endpackage

// ---- logic/cid_pin_sync.sv ----
// synchroniser: three-stage capture of an asynchronous pin with agreement filter
`timescale 1ns/100ps
module cid_pin_sync
    import cid_pkg::*;
#(
    parameter logic RST_LEVEL = NMI_RST_LEVEL
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level
);

    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1 <= RST_LEVEL;
            s2 <= RST_LEVEL;
            s3 <= RST_LEVEL;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            level <= RST_LEVEL;
        end else if (s2 == s3) begin
            level <= s2;
        end
    end

endmodule

// ---- logic/cid_decoder.sv ----
// decoder: assembles 2- or 4-byte instructions and issues them with side controls
//
// Function
// - up to two co-processor operands handed over per instruction
// - co-processor class adds multiply, accumulate and 32-bit signed arithmetic
// - add and subtract, word or byte, with or without carry, 2 or 4 bytes
// - register product of two general registers, signed or unsigned, 2 bytes
// - divide low multiply/divide register by general register, 2 bytes
// - long quotient of the full register pair by general register, 2 bytes
// - complement or negate a general register, word or byte, 2 bytes
// - bit logic and bit transfer between direct bits, 4 bytes
// - masked field modify of high or low byte, 4 bytes
// - compare then step register by one or two, 2 or 4 bytes
// - normalise count of a register into another, 2 bytes
// - shifts, rotates and signed right shift, 2 bytes
// - byte widened to word signed or zero, 2 or 4 bytes
// - bit test branches clearing or setting the tested bit, 4 bytes
// - far branch and far subroutine call, 4 bytes
// - push then call, 4 bytes
// - context switch pushes then loads a register, 4 bytes
// - return with pop of a register, 2 bytes
// - trap enters routine chosen by immediate number, 2 bytes
// - power down entered, with the nmi pin held low outside
// - end of init pin, software reset, idle, watchdog service and disable
// - prefixes open page, segment, register or uninterruptible sequences
// - every co-processor instruction is four bytes long
`timescale 1ns/100ps
module cid_decoder
    import cid_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_word,
    output logic             fetch_ready,
    output logic             want_second,
    input  wire logic        exe_ready,
    output logic             issue_valid,
    output cid_issue_t       issue,
    output logic             mac_start,
    output cid_mac_t         mac,
    input  wire logic        nmi_pin,
    input  wire logic        wake,
    output cid_sys_t         sys,
    output logic             pfx_active,
    output logic [15:0]      pfx_value
);

    cid_state_t  state;
    logic [15:0] held;
    logic [15:0] src;
    cid_op_t     first_op;
    logic        first_len4;
    logic        take;
    logic        load;
    cid_issue_t  next_issue;
    logic [2:0]  pfx_left;
    logic [1:0]  pfx_kind;
    logic        nmi_level;
    logic        sys_fire;
    logic        wdt_fire;
    logic        rst_pin_q;
    logic        soft_q;
    logic        idle_q;
    logic        pd_q;
    logic        wdt_srv_q;
    logic        wdt_dis_q;

    // opcode class of a first word; unknown codes become illegal
    function automatic cid_op_t class_of(input logic [15:0] w);
        logic [5:0] code;
        cid_op_t    op;
        code = w[OPC_LSB +: 6];
        op = OP_ILLEGAL;
        if (code < 6'(OP_ILLEGAL)) begin
            op = cid_op_t'(code);
        end
        // more operands than the co-processor path carries
        if (op == OP_COPROC && w[SUB_LSB +: 2] > MAC_MAX_OPERANDS) begin
            op = OP_ILLEGAL;
        end
        return op;
    endfunction

    // instruction length from class and sub-code alone
    function automatic logic len_is_four(input cid_op_t op, input logic [1:0] sub);
        logic four;
        four = 1'b0;
        case (op)
            OP_ADD,
            OP_SUB,
            OP_SUM_WITH_CARRY,
            OP_DIFFERENCE_WITH_BORROW: four = sub[SUB_LONG];
            OP_AND,
            OP_OR,
            OP_XOR,
            OP_CMP,
            OP_MOV: four = sub[SUB_LONG];
            OP_COMPARE_THEN_DECREMENT,
            OP_COMPARE_THEN_INCREMENT: four = sub[SUB_LONG];
            OP_BYTE_WIDEN_SIGNED,
            OP_BYTE_WIDEN_ZERO: four = sub[SUB_LONG];
            OP_REGISTER_PRODUCT: four = 1'b0;
            OP_DIVIDE: four = 1'b0;
            OP_LONG_QUOTIENT: four = 1'b0;
            OP_ONES_COMPLEMENT,
            OP_TWOS_NEGATE: four = 1'b0;
            OP_NORMALISE_COUNT: four = 1'b0;
            OP_SHIFT_ROTATE,
            OP_SIGNED_RIGHT_SHIFT: four = 1'b0;
            OP_RETURN_WITH_POP: four = 1'b0;
            OP_TRAP: four = 1'b0;
            OP_BIT_TRANSFER,
            OP_BIT_LOGIC,
            OP_BIT_COMPARE: four = 1'b1;
            OP_MASKED_FIELD_MODIFY: four = 1'b1;
            OP_BRANCH_TEST_CLEAR,
            OP_BRANCH_TEST_SET: four = 1'b1;
            OP_FAR_BRANCH,
            OP_FAR_SUBROUTINE_CALL: four = 1'b1;
            OP_PUSH_THEN_CALL: four = 1'b1;
            OP_CONTEXT_SWITCH: four = 1'b1;
            OP_SYSTEM,
            OP_WATCHDOG: four = 1'b1;
            OP_PREFIX_LONG: four = 1'b1;
            OP_COPROC: four = 1'b1;
            OP_BRANCH,
            OP_BRANCH_BIT,
            OP_CALL: four = 1'b1;
            default: four = 1'b0;
        endcase
        return four;
    endfunction

    cid_pin_sync #(
        .RST_LEVEL (NMI_RST_LEVEL)
    ) u_nmi_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (nmi_pin),
        .level (nmi_level)
    );

    // fetch handshake and length predecode
    assign first_op    = class_of(fetch_word);
    assign first_len4  = len_is_four(first_op, fetch_word[SUB_LSB +: 2]);
    assign fetch_ready = (!issue_valid || exe_ready) && !idle_q && !pd_q && !soft_q;
    assign take        = fetch_valid && fetch_ready;
    assign load        = take && (state == ST_SECOND || !first_len4);
    assign want_second = (state == ST_SECOND);
    assign src         = (state == ST_SECOND) ? held : fetch_word;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_FIRST;
        end else if (take) begin
            if (state == ST_FIRST && first_len4) begin
                state <= ST_SECOND;
            end else begin
                state <= ST_FIRST;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            held <= WORD_RST;
        end else if (take && state == ST_FIRST) begin
            held <= fetch_word;
        end
    end

    // decoded fields of the instruction completed this cycle
    always_comb begin
        next_issue       = '0;
        next_issue.op    = class_of(src);
        next_issue.sub   = src[SUB_LSB +: 2];
        next_issue.reg_a = src[REG_A_LSB +: 4];
        next_issue.reg_b = src[REG_B_LSB +: 4];
        if (state == ST_SECOND) begin
            next_issue.len4 = 1'b1;
            next_issue.ext  = fetch_word;
        end else begin
            next_issue.len4 = 1'b0;
            next_issue.ext  = WORD_RST;
        end
        if (pfx_left != PFX_LEFT_RST && next_issue.op != OP_PREFIX && next_issue.op != OP_PREFIX_LONG) begin
            next_issue.prefixed = 1'b1;
            next_issue.pfx_kind = pfx_kind;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            issue_valid <= 1'b0;
        end else if (load) begin
            issue_valid <= 1'b1;
        end else if (exe_ready) begin
            issue_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            issue <= '0;
        end else if (load) begin
            issue <= next_issue;
        end
    end

    // co-processor dispatch with its operand count and addresses
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mac_start <= 1'b0;
            mac       <= '0;
        end else begin
            mac_start <= load && next_issue.op == OP_COPROC;
            if (load && next_issue.op == OP_COPROC) begin
                mac.count  <= next_issue.sub;
                mac.addr_a <= next_issue.reg_a;
                mac.addr_b <= next_issue.reg_b;
            end
        end
    end

    // prefix sequence: count of following instructions it covers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pfx_left  <= PFX_LEFT_RST;
            pfx_kind  <= PFX_UNINTERRUPT;
            pfx_value <= WORD_RST;
        end else if (load && next_issue.op == OP_PREFIX) begin
            pfx_left  <= {1'b0, next_issue.reg_b[1:0]} + 3'h1;
            pfx_kind  <= next_issue.sub;
            pfx_value <= WORD_RST;
        end else if (load && next_issue.op == OP_PREFIX_LONG) begin
            pfx_left  <= {1'b0, next_issue.reg_b[1:0]} + 3'h1;
            pfx_kind  <= next_issue.sub[0] ? PFX_SEGMENT : PFX_PAGE;
            pfx_value <= next_issue.ext;
        end else if (load && pfx_left != PFX_LEFT_RST) begin
            pfx_left <= pfx_left - 3'h1;
        end
    end

    assign pfx_active = (pfx_left != PFX_LEFT_RST);

    // system functions act when the instruction is issued
    assign sys_fire = load && next_issue.op == OP_SYSTEM;
    assign wdt_fire = load && next_issue.op == OP_WATCHDOG;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rst_pin_q <= 1'b0;
        end else if (sys_fire && next_issue.sub == SYS_END_OF_INIT) begin
            rst_pin_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= sys_fire && next_issue.sub == SYS_SOFTWARE_RESET;
        end
    end

    // idle set wins over a wake in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            idle_q <= 1'b0;
        end else if (sys_fire && next_issue.sub == SYS_IDLE) begin
            idle_q <= 1'b1;
        end else if (wake) begin
            idle_q <= 1'b0;
        end
    end

    // power down only while the nmi pin is seen low; left only by reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pd_q <= 1'b0;
        end else if (sys_fire && next_issue.sub == SYS_POWER_DOWN && !nmi_level) begin
            pd_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wdt_srv_q <= 1'b0;
            wdt_dis_q <= 1'b0;
        end else begin
            wdt_srv_q <= wdt_fire && next_issue.sub == WDT_SERVICE;
            if (wdt_fire && next_issue.sub == WDT_DISABLE && !rst_pin_q) begin
                wdt_dis_q <= 1'b1;
            end
        end
    end

    assign sys.reset_output_pin = rst_pin_q;
    assign sys.soft_reset       = soft_q;
    assign sys.idle_mode        = idle_q;
    assign sys.power_down_mode  = pd_q;
    assign sys.wdt_service      = wdt_srv_q;
    assign sys.wdt_disabled     = wdt_dis_q;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_mac_operands: assert property (
        mac_start |-> issue_valid && issue.op == OP_COPROC && mac.count == issue.sub && mac.count <= 2'h2
    ) else $error("co-processor operand count wrong");

    a_coproc_long: assert property (
        issue_valid && issue.op == OP_COPROC |-> issue.len4
    ) else $error("co-processor instruction not four bytes");

    a_first_of_two: assert property (
        take && state == ST_FIRST && first_len4 |=> want_second && !issue_valid
    ) else $error("long instruction issued before second word");

    a_short_issue: assert property (
        take && state == ST_FIRST && !first_len4 |=> issue_valid && !issue.len4 && !want_second
    ) else $error("short instruction not issued next cycle");

    a_second_issue: assert property (
        take && state == ST_SECOND |=> issue_valid && issue.len4 && issue.ext == $past(fetch_word)
    ) else $error("extension word lost");

    a_short_forms: assert property (
        issue_valid && issue.op inside {OP_SHIFT_ROTATE, OP_SIGNED_RIGHT_SHIFT, OP_NORMALISE_COUNT,
            OP_REGISTER_PRODUCT, OP_DIVIDE, OP_LONG_QUOTIENT, OP_TRAP, OP_RETURN_WITH_POP} |-> !issue.len4
    ) else $error("two-byte form issued as four bytes");

    a_bit_forms: assert property (
        issue_valid && issue.op inside {OP_BIT_TRANSFER, OP_BIT_LOGIC, OP_MASKED_FIELD_MODIFY,
            OP_BRANCH_TEST_CLEAR, OP_BRANCH_TEST_SET, OP_PUSH_THEN_CALL, OP_CONTEXT_SWITCH} |-> issue.len4
    ) else $error("four-byte form issued as two bytes");

    a_prefix_span: assert property (
        load && next_issue.op == OP_PREFIX && next_issue.reg_b[1:0] == 2'h2 |=> pfx_left == 3'h3
    ) else $error("prefix span wrong");

    a_init_pin: assert property (
        sys_fire && next_issue.sub == SYS_END_OF_INIT |=> sys.reset_output_pin [*3]
    ) else $error("end of init pin not held");

    a_soft_pulse: assert property (
        sys_fire && next_issue.sub == SYS_SOFTWARE_RESET |=> sys.soft_reset && !fetch_ready ##1 !sys.soft_reset
    ) else $error("software reset not one pulse");

    a_idle_stall: assert property (
        sys_fire && next_issue.sub == SYS_IDLE |=> sys.idle_mode && !fetch_ready
    ) else $error("idle did not stop fetch");

    a_pd_nmi: assert property (
        $rose(sys.power_down_mode) |-> !$past(nmi_level) && $past(sys_fire)
    ) else $error("power down without nmi low");

    a_wdt_lock: assert property (
        $rose(sys.wdt_disabled) |-> !$past(rst_pin_q)
    ) else $error("watchdog disabled after end of init");

    c_long_load: cover property (take && state == ST_SECOND);
    c_mac_two: cover property (mac_start && mac.count == 2'h2);
    c_prefixed: cover property (issue_valid && issue.prefixed);
    c_idle_wake: cover property (sys.idle_mode ##1 !sys.idle_mode);

endmodule

// ---- tb/cid_pipe_model.sv ----
// partner model: fetch path and execution pipeline facing the decoder
`timescale 1ns/100ps
module cid_pipe_model (
    input  wire logic   clk,
    input  wire logic   fetch_ready,
    output logic        fetch_valid,
    output logic [15:0] fetch_word,
    output logic        exe_ready
);
    logic [15:0] q[$];
    logic        took;
    logic        go;

    initial begin
        fetch_valid = 1'b0;
        fetch_word  = 16'h0000;
        exe_ready   = 1'b1;
        go          = 1'b1;
        took        = 1'b0;
    end

    task automatic push(input logic [15:0] w);
        q.push_back(w);
    endtask

    task automatic set_ready(input logic r);
        go = r;
    endtask

    // inputs only move just after a rising edge, so this is the value seen at the next one
    always @(negedge clk) begin
        took = fetch_valid && fetch_ready;
    end

    // a word is held until taken; an empty line shows no stale value
    always @(posedge clk) begin
        if (took) begin
            void'(q.pop_front());
        end
        #1;
        exe_ready   = go;
        fetch_valid = (q.size() != 0);
        fetch_word  = (q.size() != 0) ? q[0] : ~fetch_word;
    end
endmodule

// ---- tb/testbench.sv ----
// testbench: decoder against the fetch and pipeline model
`timescale 1ns/100ps
module testbench
    import cid_pkg::*;
;
    logic        clk;
    logic        nrst;
    logic        fetch_valid;
    logic        fetch_ready;
    logic        want_second;
    logic        exe_ready;
    logic        issue_valid;
    logic        mac_start;
    logic        nmi_pin;
    logic        wake;
    logic        pfx_active;
    logic [15:0] fetch_word;
    logic [15:0] pfx_value;
    cid_issue_t  issue;
    cid_mac_t    mac;
    cid_sys_t    sys;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;

    cid_decoder dut_u (.clk(clk), .nrst(nrst), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .fetch_ready(fetch_ready), .want_second(want_second), .exe_ready(exe_ready),
        .issue_valid(issue_valid), .issue(issue), .mac_start(mac_start), .mac(mac), .nmi_pin(nmi_pin),
        .wake(wake), .sys(sys), .pfx_active(pfx_active), .pfx_value(pfx_value));

    cid_pipe_model pipe_u (.clk(clk), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
        .fetch_word(fetch_word), .exe_ready(exe_ready));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic len_of(input int c, input logic [1:0] s);
        if (c > 46) return 1'b0;
        case (cid_op_t'(c))
            OP_ADD, OP_SUM_WITH_CARRY, OP_SUB, OP_DIFFERENCE_WITH_BORROW, OP_AND, OP_OR, OP_XOR, OP_CMP, OP_MOV,
            OP_COMPARE_THEN_DECREMENT, OP_COMPARE_THEN_INCREMENT, OP_BYTE_WIDEN_SIGNED,
            OP_BYTE_WIDEN_ZERO: return s[1];
            OP_BIT_TRANSFER, OP_BIT_LOGIC, OP_BIT_COMPARE, OP_MASKED_FIELD_MODIFY, OP_BRANCH, OP_FAR_BRANCH,
            OP_BRANCH_BIT, OP_BRANCH_TEST_CLEAR, OP_BRANCH_TEST_SET, OP_CALL, OP_FAR_SUBROUTINE_CALL,
            OP_PUSH_THEN_CALL, OP_CONTEXT_SWITCH, OP_SYSTEM, OP_WATCHDOG, OP_PREFIX_LONG: return 1'b1;
            OP_COPROC: return s != 2'h3;
            default: return 1'b0;
        endcase
    endfunction

    task automatic wait_hi(input logic sel);
        int k;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            #1;
            if ((sel ? issue_valid : want_second) === 1'b1) break;
        end
        check(sel ? "issue_valid" : "want_second", sel ? issue_valid : want_second, 1'b1);
    endtask

    // one instruction through fetch to issue, judged at the issue cycle
    task automatic run_one(input int c, input logic [1:0] s, input logic [15:0] ext);
        logic    l4;
        cid_op_t op;
        l4 = len_of(c, s);
        op = (c > 46 || (c == int'(OP_COPROC) && s == 2'h3)) ? OP_ILLEGAL : cid_op_t'(c);
        pipe_u.push({c[5:0], s, 8'h5a});
        if (l4) begin
            wait_hi(1'b0);
            pipe_u.push(ext);
        end
        wait_hi(1'b1);
        check("op", issue.op, op);
        check("len4", issue.len4, l4);
        check("regs", {issue.reg_a, issue.reg_b}, 8'h5a);
        check("sub", issue.sub, s);
        if (l4) check("ext", issue.ext, ext);
        if (op == OP_COPROC) begin
            check("mac_start", mac_start, 1'b1);
            check("mac_count", mac.count, s);
            check("mac_regs", {mac.addr_a, mac.addr_b}, 8'h5a);
        end
    endtask

    task automatic t_classes();
        for (int c = 0; c < 64; c++) begin
            if (c == int'(OP_SYSTEM) || c == int'(OP_WATCHDOG)) continue;
            for (int s = 0; s < 4; s++) begin
                run_one(c, 2'(s), 16'h0f00 ^ 16'(c * 4 + s));
            end
        end
        $display("test classes done");
    endtask

    task automatic t_stall();
        // let the last issue drain so the held one is the push
        @(posedge clk);
        #1;
        pipe_u.set_ready(1'b0);
        pipe_u.push({OP_PUSH, 2'h0, 8'h12});
        pipe_u.push({OP_POP, 2'h0, 8'h34});
        wait_hi(1'b1);
        repeat (3) begin
            @(posedge clk);
            #1;
            check("held_valid", issue_valid, 1'b1);
            check("held_op", issue.op, OP_PUSH);
            check("refused", fetch_ready, 1'b0);
        end
        pipe_u.set_ready(1'b1);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            #1;
            if (issue.op === OP_POP) break;
        end
        check("next_op", issue.op, OP_POP);
        @(posedge clk);
        #1;
        check("drained", issue_valid, 1'b0);
        $display("test stall done");
    endtask

    task automatic t_prefix();
        run_one(int'(OP_PREFIX), 2'h2, 16'h0000);
        check("pfx_active", pfx_active, 1'b1);
        for (int i = 0; i < 4; i++) begin
            run_one(int'(OP_NOP), 2'h0, 16'h0000);
            check("prefixed", issue.prefixed, i < 3);
            if (i == 0) check("pfx_kind", issue.pfx_kind, PFX_PAGE);
        end
        run_one(int'(OP_PREFIX_LONG), 2'h1, 16'h0a5c);
        run_one(int'(OP_ADD), 2'h0, 16'h0000);
        check("pfx_value", pfx_value, 16'h0a5c);
        check("pfx_seg", issue.pfx_kind, PFX_SEGMENT);
        $display("test prefix done");
    endtask

    task automatic t_system();
        run_one(int'(OP_WATCHDOG), WDT_DISABLE, 16'h0001);
        check("wdt_disabled", sys.wdt_disabled, 1'b1);
        run_one(int'(OP_WATCHDOG), WDT_SERVICE, 16'h0002);
        check("wdt_service", sys.wdt_service, 1'b1);
        @(posedge clk);
        #1;
        check("wdt_pulse", sys.wdt_service, 1'b0);
        run_one(int'(OP_SYSTEM), SYS_END_OF_INIT, 16'h0003);
        check("rst_out", sys.reset_output_pin, 1'b1);
        run_one(int'(OP_SYSTEM), SYS_SOFTWARE_RESET, 16'h0004);
        check("soft_reset", sys.soft_reset, 1'b1);
        run_one(int'(OP_SYSTEM), SYS_IDLE, 16'h0005);
        repeat (3) @(posedge clk);
        #1;
        check("idle", sys.idle_mode, 1'b1);
        check("idle_refuse", fetch_ready, 1'b0);
        wake = 1'b1;
        @(posedge clk);
        #1;
        wake = 1'b0;
        check("woken", sys.idle_mode, 1'b0);
        run_one(int'(OP_SYSTEM), SYS_POWER_DOWN, 16'h0006);
        check("pd_nmi_high", sys.power_down_mode, 1'b0);
        nmi_pin = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        run_one(int'(OP_SYSTEM), SYS_POWER_DOWN, 16'h0007);
        repeat (3) @(posedge clk);
        #1;
        check("pd_mode", sys.power_down_mode, 1'b1);
        check("pd_refuse", fetch_ready, 1'b0);
        $display("test system done");
    endtask

    task automatic t_reset();
        nmi_pin = 1'b1;
        nrst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        check("rst2_sys", sys, 6'h00);
        check("rst2_valid", issue_valid, 1'b0);
        check("rst2_ready", fetch_ready, 1'b1);
        check("rst2_pfx", pfx_active, 1'b0);
        run_one(int'(OP_ADD), 2'h2, 16'h1234);
        check("rst2_prefixed", issue.prefixed, 1'b0);
        $display("test reset done");
    endtask

    initial begin
        clk     = 1'b0;
        nrst    = 1'b0;
        wake    = 1'b0;
        nmi_pin = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        check("rst_valid", issue_valid, 1'b0);
        check("rst_sys", sys, 6'h00);
        check("rst_ready", fetch_ready, 1'b1);
        t_classes();
        t_stall();
        t_prefix();
        t_system();
        t_reset();
        close_out();
    end
endmodule
